/* File: src/core_regs_pkg.sv */
// package: register offsets, field positions, reset values and core types
package core_regs_pkg;

	// ==========================================================
	// wishbone register map (byte addresses, one word each)
	localparam logic [7:0] OFS_BANK_SEL     = 8'h00;
	localparam logic [7:0] OFS_FLAGS        = 8'h04;
	localparam logic [7:0] OFS_ACC          = 8'h08;
	localparam logic [7:0] OFS_PC_LOW       = 8'h0C;
	localparam logic [7:0] OFS_TBL_PTR_LOW  = 8'h10;
	localparam logic [7:0] OFS_TBL_PTR_HIGH = 8'h14;
	localparam logic [7:0] OFS_TBL_HIGH     = 8'h18;
	localparam logic [7:0] OFS_PC_FULL      = 8'h1C;

	// ==========================================================
	// status field positions
	localparam int FLAG_C   = 0;
	localparam int FLAG_AC  = 1;
	localparam int FLAG_Z   = 2;
	localparam int FLAG_OV  = 3;
	localparam int FLAG_PDF = 4;
	localparam int FLAG_TO  = 5;
	localparam logic [7:0] FLAGS_SW_MASK = 8'h0F;

	// ==========================================================
	// reset values and the undefined bank code
	localparam logic [1:0] BANK_RESET  = 2'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [1:0] BANK_UNDEF  = 2'h3;

	// ==========================================================
	// arithmetic unit operations
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_ADD  = 4'h1,
		OP_ADC  = 4'h2,
		OP_SUB  = 4'h3,
		OP_SBC  = 4'h4,
		OP_AND  = 4'h5,
		OP_OR   = 4'h6,
		OP_XOR  = 4'h7,
		OP_RLC  = 4'h8,
		OP_RRC  = 4'h9,
		OP_MOV  = 4'hA
	} alu_op_t;

	// ==========================================================
	// core event strobes from the instruction sequencer
	typedef struct packed {
		logic alu_go;
		logic wdt_clear;
		logic halt;
		logic wdt_timeout;
		logic power_up;
	} core_evt_t;

	// data memory access request
	typedef struct packed {
		logic       valid;
		logic       we;
		logic       indirect;
		logic [6:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	// resolved data memory access
	typedef struct packed {
		logic       sfr;
		logic       gp_en;
		logic       gp_we;
		logic [1:0] bank;
		logic [6:0] addr;
	} mem_map_t;

endpackage

/* File: src/core_bank_status_regs.sv */
// core special-function logic: bank selector, accumulator, pc low, table, status
// What this block does
// RL1: three-bank selector bits 1:0 pick bank 0, 1 or 2; code 11 undefined.
// RL2: two-bank selector has one writable bit; bits 7:1 read zero.
// RL3: reset clears selector, except watchdog timeout reset during power-down.
// RL4: special function register accesses ignore the bank selector.
// RL5: direct accesses to general memory always reach bank zero.
// RL6: only indirect accesses use the selector to reach other banks.
// RL7: arithmetic results land in the accumulator; no register-to-register path.
// RL8: writing pc low byte jumps within the current program page.
// RL9: a pc low byte write inserts one dummy instruction cycle.
// RL10: table read fetches word at pointer; high byte to table high register.
// RL11: software loads table pointers before table reads, may step them.
// RL12: status writes never change timeout or power-down flags.
// RL13: timeout flag cleared by power-up, watchdog clear, halt; set on timeout.
// RL14: power-down flag cleared by power-up or watchdog clear; set by halt.
// RL15: carry set on add carry or no subtract borrow; rotates update it.
// RL16: auxiliary carry follows carry out of the low nibble.
// RL17: zero flag set when an arithmetic or logic result is zero.
// RL18: overflow set when carry into msb differs from carry out.
// RL19: calls and interrupts never save status automatically.
// RL20: software must not modify reserved data memory bytes.
// RL21: undefined bank code: indirect general reads return zero, writes ignored.
`timescale 1ns/1ps

module core_bank_status_regs
	import core_regs_pkg::*;
#(
	parameter int THREE_BANK = 1,
	parameter int PC_WIDTH   = 13,
	parameter int SFR_TOP    = 127
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// classic wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	// sequencer side
	input  wire core_regs_pkg::core_evt_t     evt_i,
	input  wire core_regs_pkg::alu_op_t       alu_op_i,
	input  wire logic [7:0]                   alu_operand_i,
	input  wire core_regs_pkg::mem_req_t      mem_req_i,
	output core_regs_pkg::mem_map_t           mem_map_o,
	input  wire logic                         table_read_i,
	input  wire logic [15:0]                  prog_word_i,
	output logic      [PC_WIDTH-1:0]          prog_addr_o,
	output logic      [7:0]                   table_low_o,
	output logic                              table_low_valid_o,
	output logic                              pc_jump_o,
	output logic                              dummy_cycle_o,
	output logic      [7:0]                   working_accumulator_o,
	output logic      [7:0]                   core_flags_o
);

	// ==========================================================
	// state
	logic [1:0]          bank_selector_reg;
	logic [7:0]          working_accumulator_reg;
	logic [7:0]          table_pointer_low_reg;
	logic [7:0]          table_pointer_high_reg;
	logic [7:0]          table_high_byte_reg;
	logic [PC_WIDTH-1:0] pc_reg;
	logic [5:0]          flags_reg;
	logic                dummy_reg;
	logic                jump_reg;
	logic [7:0]          table_low_reg;
	logic                table_low_valid_reg;
	logic                ack_reg;
	logic [31:0]         rdata_reg;

	// ==========================================================
	// bus decode
	logic       wb_req;
	logic       wb_wr;
	logic       lane0_wr;
	logic [7:0] wbyte;
	logic [1:0] bank_mask;

	assign wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wb_wr     = wb_req && wb_we_i;
	assign lane0_wr  = wb_wr && wb_sel_i[0];
	assign wbyte     = wb_dat_i[7:0];
	assign bank_mask = (THREE_BANK != 0) ? 2'h3 : 2'h1; // [RL1] [RL2]

	// ==========================================================
	// arithmetic unit
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic       c7;
	logic       cin;
	logic       is_arith;
	logic       new_c;
	logic       upd_c;

	always_comb begin
		sum      = 9'h000;
		nib      = 5'h00;
		res      = working_accumulator_reg;
		cin      = flags_reg[FLAG_C];
		is_arith = 1'b0;
		upd_c    = 1'b0;
		new_c    = flags_reg[FLAG_C];
		unique case (alu_op_i)
			OP_ADD, OP_ADC: begin
				cin      = (alu_op_i == OP_ADC) ? flags_reg[FLAG_C] : 1'b0;
				sum      = {1'b0, working_accumulator_reg} + {1'b0, alu_operand_i} + {8'h00, cin};
				nib      = {1'b0, working_accumulator_reg[3:0]} + {1'b0, alu_operand_i[3:0]}
					+ {4'h0, cin};
				res      = sum[7:0];
				is_arith = 1'b1;
			end
			OP_SUB, OP_SBC: begin
				// subtract as add of complement: carry out means no borrow
				cin      = (alu_op_i == OP_SBC) ? flags_reg[FLAG_C] : 1'b1;
				sum      = {1'b0, working_accumulator_reg} + {1'b0, ~alu_operand_i} + {8'h00, cin};
				nib      = {1'b0, working_accumulator_reg[3:0]} + {1'b0, ~alu_operand_i[3:0]}
					+ {4'h0, cin};
				res      = sum[7:0];
				is_arith = 1'b1;
			end
			OP_AND: res = working_accumulator_reg & alu_operand_i;
			OP_OR:  res = working_accumulator_reg | alu_operand_i;
			OP_XOR: res = working_accumulator_reg ^ alu_operand_i;
			OP_RLC: begin
				res   = {working_accumulator_reg[6:0], flags_reg[FLAG_C]};
				new_c = working_accumulator_reg[7];
				upd_c = 1'b1; // [RL15]
			end
			OP_RRC: begin
				res   = {flags_reg[FLAG_C], working_accumulator_reg[7:1]};
				new_c = working_accumulator_reg[0];
				upd_c = 1'b1; // [RL15]
			end
			OP_MOV:  res = alu_operand_i;
			default: res = working_accumulator_reg;
		endcase
		// carry into bit 7 recovered from operand and result bits
		c7 = res[7] ^ working_accumulator_reg[7]
			^ ((alu_op_i == OP_SUB || alu_op_i == OP_SBC) ? ~alu_operand_i[7] : alu_operand_i[7]);
	end

	logic alu_fire;
	logic is_logic;
	assign alu_fire = evt_i.alu_go && alu_op_i != OP_NONE;
	assign is_logic = alu_op_i == OP_AND || alu_op_i == OP_OR || alu_op_i == OP_XOR;

	// ==========================================================
	// bank selector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// watchdog timeout while halted keeps the selected bank
			if (!(evt_i.wdt_timeout && flags_reg[FLAG_PDF]) || evt_i.power_up) begin
				bank_selector_reg <= BANK_RESET; // [RL3]
			end
		end else if (lane0_wr && wb_adr_i == OFS_BANK_SEL) begin
			bank_selector_reg <= wbyte[1:0] & bank_mask; // [RL1] [RL2]
		end
	end

	// ==========================================================
	// data memory mapping
	always_comb begin
		mem_map_o      = '0;
		mem_map_o.addr = mem_req_i.addr;
		if (mem_req_i.valid) begin
			if (mem_req_i.addr <= 7'(SFR_TOP) && mem_req_i.addr < 7'h40) begin
				mem_map_o.sfr  = 1'b1; // [RL4]
				mem_map_o.bank = 2'h0;
			end else if (!mem_req_i.indirect) begin
				mem_map_o.gp_en = 1'b1;
				mem_map_o.gp_we = mem_req_i.we;
				mem_map_o.bank  = 2'h0; // [RL5]
			end else if (bank_selector_reg != BANK_UNDEF) begin
				mem_map_o.gp_en = 1'b1;
				mem_map_o.gp_we = mem_req_i.we;
				mem_map_o.bank  = bank_selector_reg; // [RL6]
			end
			// undefined code: no enable, read data forced to zero downstream [RL21]
		end
	end

	// ==========================================================
	// accumulator: sole destination of the arithmetic unit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			working_accumulator_reg <= BYTE_RESET;
		end else if (alu_fire) begin
			working_accumulator_reg <= res; // [RL7]
		end else if (lane0_wr && wb_adr_i == OFS_ACC) begin
			working_accumulator_reg <= wbyte;
		end
	end

	// ==========================================================
	// status flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			if (evt_i.power_up) begin
				flags_reg[FLAG_TO]  <= 1'b0; // [RL13]
				flags_reg[FLAG_PDF] <= 1'b0; // [RL14]
			end else if (evt_i.wdt_timeout) begin
				flags_reg[FLAG_TO]  <= 1'b1; // [RL13]
			end
			flags_reg[3:0] <= 4'h0;
		end else begin
			if (evt_i.wdt_timeout) begin
				flags_reg[FLAG_TO] <= 1'b1; // [RL13]
			end else if (evt_i.wdt_clear || evt_i.halt) begin
				flags_reg[FLAG_TO] <= 1'b0; // [RL13]
			end
			if (evt_i.halt) begin
				flags_reg[FLAG_PDF] <= 1'b1; // [RL14]
			end else if (evt_i.wdt_clear) begin
				flags_reg[FLAG_PDF] <= 1'b0; // [RL14]
			end
			if (alu_fire) begin
				if (is_arith) begin
					flags_reg[FLAG_C]  <= sum[8]; // [RL15]
					flags_reg[FLAG_AC] <= nib[4]; // [RL16]
					flags_reg[FLAG_OV] <= c7 ^ sum[8]; // [RL18]
				end else if (upd_c) begin
					flags_reg[FLAG_C] <= new_c; // [RL15]
				end
				if (is_arith || is_logic) begin
					flags_reg[FLAG_Z] <= (res == 8'h00); // [RL17]
				end
			end else if (lane0_wr && wb_adr_i == OFS_FLAGS) begin
				flags_reg[3:0] <= wbyte[3:0] & FLAGS_SW_MASK[3:0]; // [RL12]
			end
		end
	end

	// ==========================================================
	// program counter and dummy cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_reg    <= '0;
			jump_reg  <= 1'b0;
			dummy_reg <= 1'b0;
		end else begin
			jump_reg  <= 1'b0;
			dummy_reg <= jump_reg; // [RL9]
			if (lane0_wr && wb_adr_i == OFS_PC_LOW) begin
				pc_reg   <= {pc_reg[PC_WIDTH-1:8], wbyte}; // [RL8]
				jump_reg <= 1'b1; // [RL8]
			end else if (lane0_wr && wb_adr_i == OFS_PC_FULL) begin
				pc_reg <= wb_dat_i[PC_WIDTH-1:0];
			end
		end
	end

	// ==========================================================
	// look-up table; pointers are loaded by software before reads [RL11]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			table_pointer_low_reg  <= BYTE_RESET;
			table_pointer_high_reg <= BYTE_RESET;
			table_high_byte_reg    <= BYTE_RESET;
			table_low_reg          <= BYTE_RESET;
			table_low_valid_reg    <= 1'b0;
		end else begin
			table_low_valid_reg <= 1'b0;
			if (lane0_wr && wb_adr_i == OFS_TBL_PTR_LOW) begin
				table_pointer_low_reg <= wbyte;
			end
			if (lane0_wr && wb_adr_i == OFS_TBL_PTR_HIGH) begin
				table_pointer_high_reg <= wbyte;
			end
			if (table_read_i) begin
				table_high_byte_reg <= prog_word_i[15:8]; // [RL10]
				table_low_reg       <= prog_word_i[7:0]; // [RL10]
				table_low_valid_reg <= 1'b1;
			end
		end
	end

	// table fetch address while a read is underway, else the pc
	assign prog_addr_o = table_read_i
		? PC_WIDTH'({table_pointer_high_reg, table_pointer_low_reg}) : pc_reg; // [RL10]

	// ==========================================================
	// wishbone answer: one wait state, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg   <= wb_req;
			rdata_reg <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					OFS_BANK_SEL:     rdata_reg[1:0] <= bank_selector_reg; // [RL2]
					OFS_FLAGS:        rdata_reg[5:0] <= flags_reg;
					OFS_ACC:          rdata_reg[7:0] <= working_accumulator_reg;
					OFS_PC_LOW:       rdata_reg[7:0] <= pc_reg[7:0];
					OFS_TBL_PTR_LOW:  rdata_reg[7:0] <= table_pointer_low_reg;
					OFS_TBL_PTR_HIGH: rdata_reg[7:0] <= table_pointer_high_reg;
					OFS_TBL_HIGH:     rdata_reg[7:0] <= table_high_byte_reg;
					OFS_PC_FULL:      rdata_reg[PC_WIDTH-1:0] <= pc_reg;
					default:          rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// status is never stacked: no push path exists toward the stack [RL19]
	assign wb_ack_o              = ack_reg;
	assign wb_dat_o              = rdata_reg;
	assign pc_jump_o             = jump_reg;
	assign dummy_cycle_o         = dummy_reg;
	assign working_accumulator_o = working_accumulator_reg;
	assign core_flags_o          = {2'b00, flags_reg};
	assign table_low_o           = table_low_reg;
	assign table_low_valid_o     = table_low_valid_reg;

endmodule

/* File: verif/core_bank_status_properties.sv */
// checker: port-level properties of the core register block
`timescale 1ns/1ps
module core_bank_status_checker
	import core_regs_pkg::*;
(
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_we_i,
	input wire logic [7:0]                wb_adr_i,
	input wire logic [3:0]                wb_sel_i,
	input wire logic                      wb_ack_o,
	input wire core_regs_pkg::core_evt_t  evt_i,
	input wire core_regs_pkg::alu_op_t    alu_op_i,
	input wire logic [7:0]                alu_operand_i,
	input wire core_regs_pkg::mem_req_t   mem_req_i,
	input wire core_regs_pkg::mem_map_t   mem_map_o,
	input wire logic                      table_read_i,
	input wire logic [15:0]               prog_word_i,
	input wire logic [7:0]                table_low_o,
	input wire logic                      table_low_valid_o,
	input wire logic                      pc_jump_o,
	input wire logic                      dummy_cycle_o,
	input wire logic [7:0]                working_accumulator_o,
	input wire logic [7:0]                core_flags_o
);
	// ==========================================================
	// properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_pcl_jump: assert property (
		wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
		&& wb_adr_i == OFS_PC_LOW |=> pc_jump_o ##1 dummy_cycle_o)
		else $error("pc low write without jump and dummy cycle");
	a_dummy_cause: assert property (dummy_cycle_o |-> $past(pc_jump_o))
		else $error("dummy cycle without jump");
	a_table_fetch: assert property (
		table_read_i |=> table_low_valid_o && table_low_o == $past(prog_word_i[7:0]))
		else $error("table low byte wrong");
	a_status_locked: assert property (
		!evt_i.halt && !evt_i.wdt_clear && !evt_i.wdt_timeout
		&& !evt_i.power_up |=> $stable(core_flags_o[5:4]))
		else $error("timeout or power-down flag moved");
	a_halt_sets: assert property (
		evt_i.halt && !evt_i.power_up |=> core_flags_o[FLAG_PDF]
		&& core_flags_o[FLAG_TO] == $past(evt_i.wdt_timeout))
		else $error("halt flags wrong");
	a_clear_flags: assert property (
		evt_i.wdt_clear && !evt_i.halt && !evt_i.wdt_timeout |=> core_flags_o[5:4] == 2'h0)
		else $error("watchdog clear left flags set");
	a_direct_bank0: assert property (
		mem_req_i.valid && !mem_req_i.indirect
		&& mem_req_i.addr >= 7'h40 |-> mem_map_o.gp_en && mem_map_o.bank == 2'h0)
		else $error("direct access left bank zero");
	a_sfr_any_bank: assert property (
		mem_req_i.valid && mem_req_i.addr < 7'h40 |-> mem_map_o.sfr && !mem_map_o.gp_en)
		else $error("special register access banked");
	a_undef_dropped: assert property (mem_map_o.gp_en |-> mem_map_o.bank != BANK_UNDEF)
		else $error("undefined bank reached memory");
	a_zero_flag: assert property (
		evt_i.alu_go && alu_op_i inside {[OP_ADD:OP_XOR]}
		|=> core_flags_o[FLAG_Z] == (working_accumulator_o == 8'h00))
		else $error("zero flag disagrees with result");
	a_and_to_acc: assert property (
		evt_i.alu_go && alu_op_i == OP_AND |=> working_accumulator_o
		== ($past(working_accumulator_o) & $past(alu_operand_i)))
		else $error("logic result not in accumulator");
	// ==========================================================
	// covers
	c_read: cover property (wb_ack_o && !wb_we_i);
	c_dummy: cover property (dummy_cycle_o);
	c_table: cover property (table_low_valid_o);
	c_bank2: cover property (mem_map_o.gp_en && mem_map_o.bank == 2'h2);
endmodule

bind core_bank_status_regs core_bank_status_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .evt_i(evt_i), .alu_op_i(alu_op_i),
	.alu_operand_i(alu_operand_i), .mem_req_i(mem_req_i), .mem_map_o(mem_map_o),
	.table_read_i(table_read_i), .prog_word_i(prog_word_i), .table_low_o(table_low_o),
	.table_low_valid_o(table_low_valid_o), .pc_jump_o(pc_jump_o),
	.dummy_cycle_o(dummy_cycle_o), .working_accumulator_o(working_accumulator_o),
	.core_flags_o(core_flags_o));

/* File: verif/tb_top.sv */
// testbench: bus, event, memory map, alu and table scenarios for the core block
`timescale 1ns/1ps
module tb_top;
	import core_regs_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic        clk, rst, cyc, stb, we, trd;
	logic [7:0]  adr, opnd, tlow, acc, fl, fl_m;
	logic [31:0] wdat, dat_o, seed;
	logic [15:0] word;
	logic [12:0] paddr;
	logic        ack, tval, jmp, dum;
	core_evt_t   evt;
	alu_op_t     op;
	mem_req_t    req;
	mem_map_t    map;
	logic [31:0] exp_q[$];
	int          miscompares, compares;
	alu_op_t     ops[9] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC};
	initial begin
		{rst, cyc, stb, we, trd, adr, opnd, wdat, word} = '0;
		rst = 1'b1;
		evt = '0;
		op = OP_NONE;
		req = '0;
		seed = 32'h0000_0053;
		miscompares = 0;
		compares = 0;
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	core_bank_status_regs i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .evt_i(evt), .alu_op_i(op), .alu_operand_i(opnd), .mem_req_i(req),
		.mem_map_o(map), .table_read_i(trd), .prog_word_i(word), .prog_addr_o(paddr),
		.table_low_o(tlow), .table_low_valid_o(tval), .pc_jump_o(jmp), .dummy_cycle_o(dum),
		.working_accumulator_o(acc), .core_flags_o(fl));
	// ==========================================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
		compares++;
		if (got !== exp_v) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp_v);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one classic cycle; no latency assumed, the count only guards a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
		if (n >= 40) miscompares++;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk);
	endtask
	// note first, so the watcher finds it at the ack edge whatever the process order
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, '0);
	endtask
	always @(posedge clk) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
		chk(dat_o, exp_q.pop_front());
	task automatic rstx(input logic pu, input logic wto);
		evt <= '{1'b0, 1'b0, 1'b0, wto, pu};
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0; evt <= '0;
		@(posedge clk);
	endtask
	task automatic pulse(input core_evt_t e);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask
	// bench only maps data memory, never writes its reserved bytes
	// bank is masked out where no general memory is reached
	task automatic mm(input logic ind, input logic [6:0] a, input logic [3:0] e);
		req <= '{1'b1, 1'b0, ind, a, 8'h00};
		@(negedge clk);
		chk(32'({map.sfr, map.gp_en, map.gp_en ? map.bank : 2'h0}), 32'(e));
		@(posedge clk);
	endtask
	// expected {acc, flags}; subtract adds the inverse so carry means no borrow
	function automatic logic [15:0] alu_exp(alu_op_t o, logic [7:0] a, b, f);
		logic [8:0] s;
		logic [7:0] x, r;
		logic ci, c4, c7;
		x = (o == OP_SUB || o == OP_SBC) ? ~b : b;
		ci = (o == OP_SUB) ? 1'b1 : (o == OP_ADC || o == OP_SBC) ? f[0] : 1'b0;
		s = {1'b0, a} + {1'b0, x} + 9'(ci);
		c4 = ({1'b0, a[3:0]} + {1'b0, x[3:0]} + 5'(ci)) > 5'h0F;
		c7 = ({1'b0, a[6:0]} + {1'b0, x[6:0]} + 8'(ci)) > 8'h7F;
		case (o)
			OP_AND: return {a & b, f[7:3], (a & b) == 8'h00, f[1:0]};
			OP_OR: return {a | b, f[7:3], (a | b) == 8'h00, f[1:0]};
			OP_XOR: return {a ^ b, f[7:3], (a ^ b) == 8'h00, f[1:0]};
			OP_RLC: return {a[6:0], f[0], f[7:1], a[7]};
			OP_RRC: return {f[0], a[7:1], f[7:1], a[0]};
			default: r = s[7:0];
		endcase
		return {r, f[7:4], s[8] ^ c7, r == 8'h00, c4, s[8]};
	endfunction
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] r, p;
		logic [15:0] e;
		@(posedge clk);
		rstx(1'b1, 1'b0);
		rd(OFS_BANK_SEL, '0);
		rd(OFS_FLAGS, '0);
		bus(1'b1, 8'h24, 32'h0000_00AA);
		rd(8'h24, '0);
		bus(1'b1, OFS_BANK_SEL, 32'hFFFF_FFFF);
		rd(OFS_BANK_SEL, 32'h0000_0003);
		for (int b = 0; b < 4; b++) begin
			r = xs();
			bus(1'b1, OFS_BANK_SEL, 32'(b));
			mm(1'b0, {1'b1, r[5:0]}, 4'h4);
			mm(1'b1, {1'b1, r[5:0]}, b == 3 ? 4'h0 : 4'(4 + b));
			mm(r[6], {1'b0, r[5:0]}, 4'h8);
		end
		req <= '0;
		bus(1'b1, OFS_BANK_SEL, 32'h0000_0002);
		pulse('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
		rd(OFS_FLAGS, 32'h0000_0010);
		rstx(1'b0, 1'b1);
		rd(OFS_BANK_SEL, 32'h0000_0002);
		rd(OFS_FLAGS, 32'h0000_0030);
		bus(1'b1, OFS_FLAGS, 32'h0000_00FF);
		rd(OFS_FLAGS, 32'h0000_003F);
		pulse('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0});
		rd(OFS_FLAGS, 32'h0000_000F);
		pulse('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
		rstx(1'b0, 1'b0);
		rd(OFS_BANK_SEL, '0);
		fl_m = 8'h10;
		for (int i = 0; i < 18; i++) begin
			r = xs();
			if (i == 0) r[15:0] = 16'h8080;
			bus(1'b1, OFS_ACC, 32'(r[7:0]));
			e = alu_exp(ops[i % 9], r[7:0], r[15:8], fl_m);
			op <= ops[i % 9]; opnd <= r[15:8]; evt.alu_go <= 1'b1;
			@(posedge clk);
			evt <= '0; op <= OP_NONE;
			@(posedge clk);
			chk(32'({acc, fl}), 32'(e));
			fl_m = e[7:0];
			rd(OFS_ACC, 32'(e[15:8]));
			rd(OFS_FLAGS, 32'(fl_m));
		end
		bus(1'b1, OFS_PC_FULL, 32'h0000_1A00);
		bus(1'b1, OFS_PC_LOW, 32'h0000_0077);
		rd(OFS_PC_FULL, 32'h0000_1A77);
		for (int i = 0; i < 3; i++) begin
			p = xs();
			bus(1'b1, OFS_TBL_PTR_LOW, 32'(p[7:0]));
			bus(1'b1, OFS_TBL_PTR_HIGH, 32'(p[15:8]));
			trd <= 1'b1; word <= p[31:16];
			@(negedge clk);
			chk(32'(paddr), 32'(p[12:0]));
			@(posedge clk);
			trd <= 1'b0;
			@(negedge clk);
			chk({23'h00_0000, tval, tlow}, {23'h00_0001, p[23:16]});
			@(posedge clk);
			rd(OFS_TBL_HIGH, 32'(p[31:24]));
		end
		report_and_stop();
	end
endmodule
